// ===== design/fsb_consts.vh
`ifndef FSB_CONSTS_VH
`define FSB_CONSTS_VH

// ------------------------------------------------------------
// array geometry
// ------------------------------------------------------------
`define FSB_ADDR_W 17
`define FSB_DEPTH 131072
`define FSB_DATA_W 18
`define FSB_LANE_W 9
`define FSB_LANES 2
`define FSB_BURST_W 2

// ------------------------------------------------------------
// access kinds held for the burst
// ------------------------------------------------------------
`define FSB_OP_IDLE 2'h0
`define FSB_OP_READ 2'h1
`define FSB_OP_WRITE 2'h2

// ------------------------------------------------------------
// burst order strap values and reset values
// ------------------------------------------------------------
`define FSB_ORDER_LINEAR 1'b0
`define FSB_ORDER_INTERLEAVED 1'b1
`define FSB_ORDER_RESET 1'b1
`define FSB_DATA_RESET 18'h00000
`define FSB_CNT_RESET 2'h0

`endif

// ===== design/fsb_burst_ctr.v
`timescale 1ns/1ps
`default_nettype none

`include "fsb_consts.vh"

module fsb_burst_ctr (
   input wire mclk_i,
   input wire rst_i,
   input wire ce_i,
   input wire load_i,
   input wire advance_i,
   input wire [`FSB_BURST_W-1:0] seed_i,
   input wire order_i,
   output wire [`FSB_BURST_W-1:0] lo_addr_o
);

   reg [`FSB_BURST_W-1:0] base_q;
   reg [`FSB_BURST_W-1:0] cnt_q;
   wire [`FSB_BURST_W-1:0] cnt_d;

   // ------------------------------------------------------------
   // address order for a step count
   // ------------------------------------------------------------
   function [`FSB_BURST_W-1:0] fsb_order;
      input [`FSB_BURST_W-1:0] base;
      input [`FSB_BURST_W-1:0] cnt;
      input order;
      begin
         if (order == `FSB_ORDER_LINEAR) begin
            fsb_order = base + cnt;
         end else begin
            fsb_order = base ^ cnt;
         end
      end
   endfunction

   // step count of the access taken at this edge
   assign cnt_d = load_i ? `FSB_CNT_RESET : cnt_q + 2'h1;
   assign lo_addr_o = load_i ? seed_i : fsb_order(base_q, cnt_d, order_i);

   // seed on load, step on advance, hold while clock is masked
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         base_q <= `FSB_CNT_RESET;
         cnt_q <= `FSB_CNT_RESET;
      end else if (ce_i) begin
         if (load_i) begin
            base_q <= seed_i;
            cnt_q <= `FSB_CNT_RESET;
         end else if (advance_i) begin
            cnt_q <= cnt_d;
         end
      end
   end

endmodule // fsb_burst_ctr

`default_nettype wire

// ===== design/fsb_sram_port.v
// How it works
// - every synchronous input is registered on the rising clock edge
// - clock qualifier high freezes all state, extending the previous cycle
// - an edge counts only while the clock qualifier is low
// - address picks one of 128K words; low two bits seed the burst counter
// - burst counter runs linear or interleaved order
// - strap low gives linear order, strap high gives interleaved
// - two active-low byte lane selects gate each lane of a write
// - write enable at a counted load edge with all enables on: low starts a write, high a read; deselected gives idle
// - advance high steps the burst counter of the current burst
// - advance low loads a new external address
// - three chip enables select jointly; first is active low
// - second chip enable is active high
// - third chip enable is active low
// - data drivers are off during every write data phase
// - output enable is masked in write data, after deselect, while deselected
// - reads and writes mix back to back, one word per counted cycle
// - asynchronous active-low output enable gates the data drivers
`timescale 1ns/1ps
`default_nettype none

`include "fsb_consts.vh"

module fsb_sram_port (
   input wire mclk_i,
   input wire rst_i,
   input wire clock_qualify_n_i,
   input wire [`FSB_ADDR_W-1:0] addr_i,
   input wire write_en_n_i,
   input wire [`FSB_LANES-1:0] byte_lane_write_n_i,
   input wire advance_or_load_i,
   input wire select_one_n_i,
   input wire select_two_i,
   input wire select_three_n_i,
   input wire out_en_n_i,
   input wire burst_order_i,
   input wire [`FSB_DATA_W-1:0] dq_i,
   output reg [`FSB_DATA_W-1:0] dq_o,
   output wire dq_oe_n_o
);

   // ------------------------------------------------------------
   // access kinds held for the burst
   // ------------------------------------------------------------
   localparam [1:0] FSB_ST_IDLE = `FSB_OP_IDLE;
   localparam [1:0] FSB_ST_READ = `FSB_OP_READ;
   localparam [1:0] FSB_ST_WRITE = `FSB_OP_WRITE;

   // ------------------------------------------------------------
   // storage and state
   // ------------------------------------------------------------
   reg [`FSB_DATA_W-1:0] mem [0:`FSB_DEPTH-1];
   reg [1:0] op_q;
   reg [1:0] op_d;
   reg [`FSB_ADDR_W-1:`FSB_BURST_W] hi_addr_q;
   reg [`FSB_ADDR_W-1:`FSB_BURST_W] hi_addr_d;
   reg wr_pend_q;
   reg [`FSB_ADDR_W-1:0] wr_addr_q;
   reg drive_q;
   reg order_q;

   wire ce;
   wire load;
   wire selected;
   wire [`FSB_BURST_W-1:0] lo_addr;
   wire [`FSB_ADDR_W-1:0] acc_addr;
   wire [`FSB_DATA_W-1:0] rd_word;
   wire fwd_hit;
   wire wr_take;
   wire burst_live;

   // ------------------------------------------------------------
   // byte lane merge, used by the array write and the bypass
   // ------------------------------------------------------------
   function [`FSB_DATA_W-1:0] fsb_merge;
      input [`FSB_DATA_W-1:0] old_word;
      input [`FSB_DATA_W-1:0] new_word;
      input [`FSB_LANES-1:0] lane_n;
      integer i;
      begin
         fsb_merge = old_word;
         for (i = 0; i < `FSB_LANES; i = i + 1) begin
            if (!lane_n[i]) begin
               fsb_merge[i*`FSB_LANE_W +: `FSB_LANE_W] =
                  new_word[i*`FSB_LANE_W +: `FSB_LANE_W];
            end
         end
      end
   endfunction

   // ------------------------------------------------------------
   // edge qualification and command decode
   // ------------------------------------------------------------
   // edge is counted only with the qualifier low
   assign ce = ~clock_qualify_n_i;
   assign load = ~advance_or_load_i;
   // all three enables must agree
   assign selected = ~select_one_n_i & select_two_i & ~select_three_n_i;

   // access kind and upper address for this edge
   always @* begin
      op_d = op_q;
      hi_addr_d = hi_addr_q;
      if (load) begin
         if (!selected) begin
            op_d = FSB_ST_IDLE;
         end else if (!write_en_n_i) begin
            op_d = FSB_ST_WRITE;
         end else begin
            op_d = FSB_ST_READ;
         end
         hi_addr_d = addr_i[`FSB_ADDR_W-1:`FSB_BURST_W];
      end
   end

   // write taken at this edge, and a live burst that may step
   assign wr_take = (op_d == FSB_ST_WRITE);
   assign burst_live = (op_q != FSB_ST_IDLE);

   // ------------------------------------------------------------
   // burst counter
   // ------------------------------------------------------------
   fsb_burst_ctr u_burst (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .ce_i(ce),
      .load_i(load),
      .advance_i(burst_live),
      .seed_i(addr_i[`FSB_BURST_W-1:0]),
      .order_i(order_q),
      .lo_addr_o(lo_addr)
   );

   // full word address of the access taken at this edge
   assign acc_addr = {hi_addr_d, lo_addr};

   // read word, bypassing a write retiring at the same edge
   assign fwd_hit = wr_pend_q && (wr_addr_q == acc_addr);
   assign rd_word = fwd_hit ? fsb_merge(mem[acc_addr], dq_i, byte_lane_write_n_i) :
      mem[acc_addr];

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   // strap taken on counted edges, so a masked edge keeps the order
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         order_q <= `FSB_ORDER_RESET;
      end else if (ce) begin
         order_q <= burst_order_i;
      end
   end

   // command pipeline, frozen while the clock is masked
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         op_q <= FSB_ST_IDLE;
         hi_addr_q <= {(`FSB_ADDR_W-`FSB_BURST_W){1'h0}};
      end else if (ce) begin
         op_q <= op_d;
         hi_addr_q <= hi_addr_d;
      end
   end

   // ------------------------------------------------------------
   // write data phase
   // ------------------------------------------------------------
   // data phase follows its command by one counted edge
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_pend_q <= 1'h0;
         wr_addr_q <= {`FSB_ADDR_W{1'h0}};
      end else if (ce) begin
         wr_pend_q <= wr_take;
         wr_addr_q <= acc_addr;
      end
   end

   // ------------------------------------------------------------
   // read data and direction
   // ------------------------------------------------------------
   // drivers on only in a read data phase
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         drive_q <= 1'h0;
         dq_o <= `FSB_DATA_RESET;
      end else if (ce) begin
         case (op_d)
            FSB_ST_READ: begin
               drive_q <= 1'h1;
               dq_o <= rd_word;
            end
            FSB_ST_WRITE: begin
               drive_q <= 1'h0;
            end
            FSB_ST_IDLE: begin
               drive_q <= 1'h0;
            end
            default: begin
               drive_q <= 1'h0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // array write
   // ------------------------------------------------------------
   // retire pending write with data taken one edge late
   always @(posedge mclk_i) begin
      if (ce && wr_pend_q) begin
         mem[wr_addr_q] <= fsb_merge(mem[wr_addr_q], dq_i, byte_lane_write_n_i);
      end
   end

   // ------------------------------------------------------------
   // data pin direction
   // ------------------------------------------------------------
   // async output enable gated by the synchronous direction
   assign dq_oe_n_o = ~(drive_q & ~out_en_n_i);

endmodule // fsb_sram_port

`default_nettype wire

// ===== test/fsb_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module fsb_port_sva (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic clock_qualify_n_i,
   input wire logic advance_or_load_i,
   input wire logic write_en_n_i,
   input wire logic select_one_n_i,
   input wire logic select_two_i,
   input wire logic select_three_n_i,
   input wire logic out_en_n_i,
   input wire logic [17:0] dq_o,
   input wire logic dq_oe_n_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // counted load and selection terms
   wire ld = !clock_qualify_n_i && !advance_or_load_i;
   wire sel = !select_one_n_i && select_two_i && !select_three_n_i;
   sequence s_rd; ld && sel && write_en_n_i; endsequence
   sequence s_wr; ld && sel && !write_en_n_i; endsequence
   sequence s_desel; ld && !sel; endsequence
   sequence s_adv; !clock_qualify_n_i && advance_or_load_i; endsequence
   chk_oe_async: assert property (!dq_oe_n_o |-> !out_en_n_i)
      else $error("pins driven with output enable high");
   chk_write_off: assert property (s_wr |=> dq_oe_n_o)
      else $error("pins driven in write data phase");
   chk_read_drive: assert property (s_rd ##1 !out_en_n_i |-> !dq_oe_n_o)
      else $error("read not driven");
   chk_one_off: assert property (ld && select_one_n_i |=> dq_oe_n_o)
      else $error("driven with first enable off");
   chk_two_off: assert property (ld && !select_two_i |=> dq_oe_n_o)
      else $error("driven with second enable off");
   chk_three_off: assert property (ld && select_three_n_i |=> dq_oe_n_o)
      else $error("driven with third enable off");
   chk_adv_idle: assert property (s_desel ##1 s_adv |=> dq_oe_n_o)
      else $error("advance after deselect drove pins");
   chk_masked_hold: assert property (clock_qualify_n_i |=> $stable(dq_o))
      else $error("read data moved on masked edge");
endmodule // fsb_port_sva
bind fsb_sram_port fsb_port_sva i_fsb_port_sva (.mclk_i, .rst_i, .clock_qualify_n_i,
   .advance_or_load_i, .write_en_n_i, .select_one_n_i, .select_two_i, .select_three_n_i,
   .out_en_n_i, .dq_o, .dq_oe_n_o);
`default_nettype wire

// ===== test/fsb_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// controller model
// ------------------------------------------------------------
module fsb_ctl_model (
   input wire logic mclk_i,
   output logic cq_n_o = 1'b1,
   output logic adv_o = 1'b0,
   output logic we_n_o = 1'b1,
   output logic [2:0] sel_o = 3'h5,
   output logic [16:0] addr_o = 17'h00000,
   output logic [17:0] dq_o = 18'h00000,
   output logic [1:0] bw_n_o = 2'h3
);
   logic pend_q = 1'b0;
   logic [17:0] pend_d_q = 18'h00000;
   logic [1:0] pend_bw_q = 2'h3;
   // one controller cycle, driven at the edge after the call, taken at the edge after that
   task automatic cyc(input logic cq_n, adv, we_n, input logic [2:0] sel,
      input logic [16:0] a, input logic [17:0] d, input logic [1:0] bw, input logic wr);
      @(posedge mclk_i);
      cq_n_o <= cq_n;
      adv_o <= adv;
      we_n_o <= we_n;
      sel_o <= sel;
      addr_o <= a;
      // data one counted cycle late, otherwise a toggling bus
      dq_o <= pend_q ? pend_d_q : ~dq_o;
      bw_n_o <= pend_q ? pend_bw_q : ~bw_n_o;
      if (!cq_n) begin
         pend_q <= wr;
         pend_d_q <= d;
         pend_bw_q <= bw;
      end
   endtask
endmodule // fsb_ctl_model
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", n, e, s); end end
// ------------------------------------------------------------
// bench top
// ------------------------------------------------------------
module testbench;
   logic mclk_i, rst_i = 1'b1, oe_n = 1'b0, order = 1'b0, cq_n, adv, we_n, pv, oe_rd_n;
   logic fill = 1'b0;
   logic [2:0] sel;
   logic [16:0] addr, base, pa;
   logic [17:0] dq_w, dq_rd, pd, ed;
   logic [1:0] bw, pb, k, kind;
   logic [17:0] mem [int];
   int fail_count = 0, checks_done = 0, r;
   fsb_ctl_model i_fsb_ctl_model (.mclk_i(mclk_i), .cq_n_o(cq_n), .adv_o(adv),
      .we_n_o(we_n), .sel_o(sel), .addr_o(addr), .dq_o(dq_w), .bw_n_o(bw));
   fsb_sram_port i_fsb_sram_port (.mclk_i(mclk_i), .rst_i(rst_i), .clock_qualify_n_i(cq_n),
      .addr_i(addr), .write_en_n_i(we_n), .byte_lane_write_n_i(bw), .advance_or_load_i(adv),
      .select_one_n_i(sel[2]), .select_two_i(sel[1]), .select_three_n_i(sel[0]),
      .out_en_n_i(oe_n), .burst_order_i(order), .dq_i(dq_w), .dq_o(dq_rd),
      .dq_oe_n_o(oe_rd_n));
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   // lane merge of a write
   function automatic logic [17:0] mrg(input logic [17:0] o, n, input logic [1:0] b);
      mrg = o;
      if (!b[0]) mrg[8:0] = n[8:0];
      if (!b[1]) mrg[17:9] = n[17:9];
   endfunction
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // drive one cycle, check the previous one, then track it
   task automatic step(input logic cq, ad, we, input logic [2:0] s, input logic [16:0] a);
      logic [17:0] d;
      logic [1:0] b;
      logic oe;
      logic [16:0] ea;
      d = 18'($urandom);
      b = fill ? 2'h0 : 2'($urandom);
      oe = ($urandom % 4) == 0;
      i_fsb_ctl_model.cyc(cq, ad, we, s, a, d, b, !cq && (ad ? kind == 2'h2 : !we && s == 3'h2));
      oe_n <= oe;
      #1;
      `CHK("dq_oe_n_o", !(kind == 2'h1 && !oe), oe_rd_n)
      if (kind == 2'h1 && ^ed !== 1'bX)
         `CHK("dq_o", ed, dq_rd)
      if (!cq) begin
         if (pv) mem[pa] = mrg(mem.exists(pa) ? mem[pa] : 18'hX, pd, pb);
         pv = 1'b0;
         if (!ad) begin
            kind = (s != 3'h2) ? 2'h0 : (we ? 2'h1 : 2'h2);
            base = a;
            k = 2'h0;
         end else
            k = k + 2'h1;
         ea = {base[16:2], order ? base[1:0] ^ k : base[1:0] + k};
         if (kind == 2'h2) begin
            pv = 1'b1;
            pa = ea;
            pd = d;
            pb = b;
         end
         ed = mem.exists(ea) ? mem[ea] : 18'hX;
      end
   endtask
   initial begin
      #20000;
      fail_count++;
      complete_run;
   end
   initial begin
      r = $urandom(49449);
      for (int ph = 0; ph < 2; ph++) begin
         @(posedge mclk_i);
         rst_i <= 1'b1;
         order <= ph[0];
         pv = 1'b0;
         kind = 2'h0;
         repeat (4) step(1'b0, 1'b0, 1'b1, 3'h5, 17'h00000);
         @(posedge mclk_i);
         rst_i <= 1'b0;
         // full-lane write burst across the wrap, bypass read, masked edge
         fill = 1'b1;
         step(1'b0, 1'b0, 1'b0, 3'h2, 17'h1FFFF);
         step(1'b0, 1'b1, 1'b1, 3'h2, 17'h00000);
         fill = 1'b0;
         step(1'b0, 1'b0, 1'b1, 3'h2, order ? 17'h1FFFE : 17'h1FFFC);
         step(1'b1, 1'b1, 1'b1, 3'h2, 17'h00000);
         // wrapped read back, then advance after deselect on purpose
         step(1'b0, 1'b0, 1'b1, 3'h2, 17'h1FFFF);
         step(1'b0, 1'b1, 1'b1, 3'h2, 17'h00000);
         step(1'b0, 1'b0, 1'b1, 3'h6, 17'h00000);
         step(1'b0, 1'b1, 1'b1, 3'h2, 17'h00000);
         repeat (200) begin
            r = $urandom % 8;
            step(r == 0, r > 4 && kind != 2'h0, 1'($urandom),
               ($urandom % 6 == 0) ? 3'($urandom) : 3'h2, 17'($urandom % 32));
         end
      end
      complete_run;
   end
endmodule // testbench
`default_nettype wire
